// file: demod_monitor_pkg.sv
// Constants shared by the demodulator monitor converter
package demod_monitor_pkg;

    // ------------------------------------------------------------
    // Register byte offsets on the APB bus
    // ------------------------------------------------------------
    localparam logic [7:0] test_mode_control_off   = 8'h00;
    localparam logic [7:0] monitor_offset_gain_off = 8'h04;
    localparam logic [7:0] monitor_config_off      = 8'h08;
    localparam logic [7:0] monitor_status_off      = 8'h0c;

    // ------------------------------------------------------------
    // Serial address codes carried in the low nibble
    // ------------------------------------------------------------
    localparam logic [3:0] test_mode_code   = 4'hc;
    localparam logic [3:0] offset_gain_code = 4'hd;
    localparam int         code_lsb         = 0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int         test_mode_lsb    = 4;
    localparam int         stretch_lsb      = 12;
    localparam int         offset_lsb       = 16;
    localparam int         gain_lsb         = 28;
    localparam int         select_bit       = 0;
    localparam int         divider_lsb      = 4;
    localparam int         status_in_lsb    = 16;

    // ------------------------------------------------------------
    // Test-mode values that switch the monitor on
    // ------------------------------------------------------------
    localparam logic [3:0] mode_plain       = 4'h7;
    localparam logic [3:0] mode_offset      = 4'ha;

    // ------------------------------------------------------------
    // Reset values and converter constants
    // ------------------------------------------------------------
    localparam logic [31:0] test_mode_reset   = 32'h0000_000c;
    localparam logic [31:0] offset_gain_reset = 32'h0000_000d;
    localparam logic [31:0] config_reset      = 32'h0000_0010;
    localparam logic [19:0] full_scale        = 20'h07fff;
    localparam int          offset_shift      = 3;

endpackage

// file: demod_monitor_sigma_delta.sv
// Demodulator monitor path: input select, offset/gain, sigma-delta
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// [RULE1] 16-bit value to bitstream, 2nd-order error feedback
// [RULE2] Bitstream drives the dedicated monitor pin
// [RULE3] Demod on pclk, modulator on recovery tick
// [RULE4] Software should run recovery clock fast
// [RULE5] Recovery block stops at full rate
// [RULE6] Test mode 7: monitor on, no offset
// [RULE7] Test mode 10: monitor on, offset removed
// [RULE8] Linear or correlator output is multiplexed in
// [RULE9] Active demodulator feeds the monitor
// [RULE10] Input is 2^gain times (signal - offset/4096)
// [RULE11] Offset magnitude stays below full scale
// [RULE12] Stretch field gives (value+1) pulse width
// [RULE13] Offset/gain writes need code 1101 low
// [RULE14] Gain in bits 31:28, offset in 27:16
//
// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
// 0x00 test_mode_control   write only
//      [3:0] address code 1100, [7:4] digital test mode
// 0x04 monitor_offset_gain write only
//      [3:0] address code 1101, [15:12] pulse stretch,
//      [27:16] offset term, [31:28] gain exponent
// 0x08 monitor_config      read and write
//      [0] 1 = correlator, 0 = linear; [11:4] recovery divider
// 0x0c monitor_status      read only
//      [0] enabled, [1] recovery running, [2] current bit,
//      [31:16] converter input after offset, gain and saturation
// Writes with a wrong address code are refused with pslverr,
// so a stray serial-style word cannot land in the wrong place.
//
module demod_monitor_sigma_delta (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] linear_demod,
    input  wire logic [15:0] corr_demod,
    output logic             monitor_bitstream_pin,
    output logic             recovery_active
);

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic monitor_on(input logic [3:0] mode);
        monitor_on = (mode == demod_monitor_pkg::mode_plain) ||
                     (mode == demod_monitor_pkg::mode_offset);
    endfunction

    function automatic logic [3:0] mode_of(input logic [31:0] r);
        mode_of = r[demod_monitor_pkg::test_mode_lsb +: 4];
    endfunction

    // Register picked by one APB byte address
    typedef enum logic [2:0] {
        sel_none   = 3'b000,
        sel_mode   = 3'b001,
        sel_gain   = 3'b010,
        sel_config = 3'b011,
        sel_status = 3'b100
    } reg_sel_e;

    // Used by both the refusal check and the write strobe
    function automatic reg_sel_e reg_of(input logic [7:0] a);
        if (a == demod_monitor_pkg::test_mode_control_off) begin
            reg_of = sel_mode;
        end else if (a == demod_monitor_pkg::monitor_offset_gain_off) begin
            reg_of = sel_gain;
        end else if (a == demod_monitor_pkg::monitor_config_off) begin
            reg_of = sel_config;
        end else if (a == demod_monitor_pkg::monitor_status_off) begin
            reg_of = sel_status;
        end else begin
            reg_of = sel_none;
        end
    endfunction

    // Status word as software sees it
    function automatic logic [31:0] status_word(
        input logic [15:0] x,
        input logic        bit_now,
        input logic        rec,
        input logic        en
    );
        status_word = {x, 13'h0, bit_now, rec, en};
    endfunction

    // ------------------------------------------------------------
    // Register file and APB slave
    // ------------------------------------------------------------
    logic [31:0] test_mode_control;
    logic [31:0] monitor_offset_gain;
    logic [31:0] monitor_config;
    logic [31:0] next_test_mode_control;
    logic [31:0] next_monitor_offset_gain;
    logic [31:0] next_monitor_config;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        setup;
    logic        bad_access;
    logic [15:0] conv_in;
    logic        enabled;
    logic        write_now;
    logic [3:0]  code;
    reg_sel_e    sel;

    assign setup     = psel && !penable;
    assign sel       = reg_of(paddr);
    assign code      = pwdata[demod_monitor_pkg::code_lsb +: 4];
    // pready is registered from setup, so access is always one cycle
    assign write_now = psel && penable && pready && pwrite && !pslverr;

    always_comb begin
        next_test_mode_control   = test_mode_control;
        next_monitor_offset_gain = monitor_offset_gain;
        next_monitor_config      = monitor_config;
        next_prdata              = 32'h0000_0000;
        next_pready              = setup;
        next_pslverr             = 1'b0;
        bad_access               = 1'b0;
        if (sel == sel_mode) begin
            bad_access = !pwrite ||
                (code != demod_monitor_pkg::test_mode_code);
        end else if (sel == sel_gain) begin
            bad_access = !pwrite ||
                (code != demod_monitor_pkg::offset_gain_code); // [RULE13]
        end else if (sel == sel_config) begin
            bad_access = 1'b0;
        end else if (sel == sel_status) begin
            bad_access = pwrite;
        end else begin
            bad_access = 1'b1;
        end
        if (setup) begin
            next_pslverr = bad_access;
            if (!pwrite) begin
                if (sel == sel_config) begin
                    next_prdata = monitor_config;
                end else if (sel == sel_status) begin
                    next_prdata = status_word(conv_in,
                                              monitor_bitstream_pin,
                                              recovery_active, enabled);
                end
            end
        end
        // Write lands only at the completing edge, and only if legal
        if (write_now) begin
            if (sel == sel_mode) begin
                next_test_mode_control = pwdata;
            end else if (sel == sel_gain) begin
                next_monitor_offset_gain = pwdata; // [RULE13]
            end else if (sel == sel_config) begin
                next_monitor_config = pwdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_mode_control   <= demod_monitor_pkg::test_mode_reset;
            monitor_offset_gain <= demod_monitor_pkg::offset_gain_reset;
            monitor_config      <= demod_monitor_pkg::config_reset;
            prdata              <= 32'h0000_0000;
            pready              <= 1'b0;
            pslverr             <= 1'b0;
        end else begin
            test_mode_control   <= next_test_mode_control;
            monitor_offset_gain <= next_monitor_offset_gain;
            monitor_config      <= next_monitor_config;
            prdata              <= next_prdata;
            pready              <= next_pready;
            pslverr             <= next_pslverr;
        end
    end

    // ------------------------------------------------------------
    // Input select, offset removal and gain (demodulator clock)
    // ------------------------------------------------------------
    logic [3:0]         mode;
    logic [3:0]         gain;
    logic [11:0]        offset;
    logic [3:0]         stretch;
    logic [7:0]         divider;
    logic signed [15:0] signal_in;
    logic signed [17:0] offset_term;
    logic signed [17:0] diff;
    logic signed [33:0] scaled;
    logic [15:0]        next_conv_in;

    assign mode    = mode_of(test_mode_control);
    assign gain    = monitor_offset_gain[demod_monitor_pkg::gain_lsb +: 4];
    assign offset  =
        monitor_offset_gain[demod_monitor_pkg::offset_lsb +: 12]; // [RULE14]
    assign stretch =
        monitor_offset_gain[demod_monitor_pkg::stretch_lsb +: 4];
    assign divider = monitor_config[demod_monitor_pkg::divider_lsb +: 8];

    always_comb begin
        // Mux follows whichever demodulator software selected
        if (monitor_config[demod_monitor_pkg::select_bit]) begin
            signal_in = signed'(corr_demod); // [RULE8] [RULE9]
        end else begin
            signal_in = signed'(linear_demod); // [RULE8] [RULE9]
        end
        // Offset/4096 of full scale is offset<<3 in 16-bit units;
        // a 12-bit field therefore never reaches 1.0
        offset_term = 18'sh00000;
        if (mode == demod_monitor_pkg::mode_offset) begin
            offset_term = signed'({3'b000, offset, 3'b000}); // [RULE7] [RULE11]
        end
        diff   = 18'(signal_in) - offset_term; // [RULE10]
        scaled = 34'(diff) <<< gain; // [RULE10]
        // Saturate rather than wrap: wrap would flip the sign
        if (scaled > 34'sh0_0000_7fff) begin
            next_conv_in = 16'h7fff;
        end else if (scaled < -34'sh0_0000_8000) begin
            next_conv_in = 16'h8000;
        end else begin
            next_conv_in = scaled[15:0];
        end
    end

    // ------------------------------------------------------------
    // Recovery-clock tick and sigma-delta modulator
    // ------------------------------------------------------------
    // One clock only: the recovery clock is a divided tick of pclk.
    // This keeps the converter input and the modulator in one
    // domain, so conv_in needs no crossing logic. The price is that
    // the recovery rate can only be pclk divided by an integer.
    // Divider 0 or 1 gives a tick on every edge: the modulator then
    // runs at the demodulator rate and clock recovery is stopped.
    // A stretched bit holds for (stretch + 1) ticks; the loop only
    // advances on the tick that starts a new bit, so the density of
    // ones still follows the input.
    logic [7:0]         tick_cnt;
    logic [3:0]         hold_cnt;
    logic signed [19:0] err1;
    logic signed [19:0] err2;
    logic [7:0]         next_tick_cnt;
    logic [3:0]         next_hold_cnt;
    logic signed [19:0] next_err1;
    logic signed [19:0] next_err2;
    logic               next_bit;
    logic               next_enabled;
    logic               next_recovery_active;
    logic               tick;
    logic signed [19:0] loop_sum;
    logic signed [19:0] feedback;

    always_comb begin
        next_enabled         = monitor_on(mode); // [RULE6] [RULE7]
        // Divide of 0 or 1 means the modulator runs at demod rate and recovery stops
        next_recovery_active = divider > 8'h01; // [RULE5]
        tick          = 1'b0;
        next_tick_cnt = tick_cnt + 8'h01;
        if (tick_cnt + 8'h01 >= divider) begin
            tick          = 1'b1; // [RULE3]
            next_tick_cnt = 8'h00;
        end
        next_hold_cnt = hold_cnt;
        next_err1     = err1;
        next_err2     = err2;
        next_bit      = monitor_bitstream_pin;
        // e[n] = v - y; v = x + 2e[n-1] - e[n-2]
        loop_sum = 20'(signed'(conv_in)) + (err1 <<< 1) - err2; // [RULE1]
        if (loop_sum >= 20'sh00000) begin
            feedback = signed'(demod_monitor_pkg::full_scale);
        end else begin
            feedback = -signed'(demod_monitor_pkg::full_scale);
        end
        if (!enabled) begin
            next_hold_cnt = 4'h0;
            next_err1     = 20'sh00000;
            next_err2     = 20'sh00000;
            next_bit      = 1'b0;
        end else if (tick) begin
            if (hold_cnt == 4'h0) begin
                next_bit      = loop_sum >= 20'sh00000; // [RULE1] [RULE2]
                next_err2     = err1;
                next_err1     = loop_sum - feedback; // [RULE1]
                next_hold_cnt = stretch; // [RULE12]
            end else begin
                next_hold_cnt = hold_cnt - 4'h1; // [RULE12]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_in               <= 16'h0000;
            enabled               <= 1'b0;
            recovery_active       <= 1'b0;
            tick_cnt              <= 8'h00;
            hold_cnt              <= 4'h0;
            err1                  <= 20'sh00000;
            err2                  <= 20'sh00000;
            monitor_bitstream_pin <= 1'b0;
        end else begin
            conv_in               <= next_conv_in;
            enabled               <= next_enabled;
            recovery_active       <= next_recovery_active;
            tick_cnt              <= next_tick_cnt;
            hold_cnt              <= next_hold_cnt;
            err1                  <= next_err1;
            err2                  <= next_err2;
            monitor_bitstream_pin <= next_bit;
        end
    end

endmodule

// file: bitstream_meter.sv
// Meter model of the external filter on the monitor bitstream pin
`timescale 1ns/1ps
module bitstream_meter (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        gate,
    input  wire logic        bitstream,
    output logic      [15:0] ones
);
    logic [15:0] next_ones;

    // Counting ones over a gate stands in for the analog low-pass filter
    always_comb begin
        next_ones = gate ? ones + 16'(bitstream) : 16'h0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ones <= 16'h0;
        end else begin
            ones <= next_ones;
        end
    end
endmodule

// file: demod_monitor_sigma_delta_monitor.sv
// Assertion checker for the demodulator monitor converter
`timescale 1ns/1ps
module demod_monitor_sigma_delta_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] linear_demod,
    input wire logic [15:0] corr_demod,
    input wire logic        monitor_bitstream_pin,
    input wire logic        recovery_active
);
    logic [3:0] mode, next_mode, stable, next_stable;
    logic [7:0] div, next_div;
    logic       wr_ok;

    assign wr_ok = psel && penable && pready && pwrite && !pslverr;

    // Shadow of accepted writes; stable gives the outputs time to settle
    always_comb begin
        next_mode   = (wr_ok && paddr == 8'h00) ? pwdata[7:4] : mode;
        next_div    = (wr_ok && paddr == 8'h08) ? pwdata[11:4] : div;
        next_stable = wr_ok ? 4'h0 : stable + 4'(stable != 4'hf);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {mode, div, stable} <= {4'h0, 8'h1, 4'h0};
        end else begin
            {mode, div, stable} <= {next_mode, next_div, next_stable};
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup; psel && !penable; endsequence
    sequence s_wr_gain; s_setup ##0 pwrite && paddr == 8'h04; endsequence

    property p_ready; s_setup |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held too long");
    property p_bad_code;
        s_wr_gain ##0 pwdata[3:0] != 4'hd |=> pready && pslverr;
    endproperty
    a_bad_code: assert property (p_bad_code)
        else $error("bad address code accepted");
    property p_good_code;
        s_wr_gain ##0 pwdata[3:0] == 4'hd |=> pready && !pslverr;
    endproperty
    a_good_code: assert property (p_good_code)
        else $error("good address code refused");
    property p_idle_zero; !pready |-> prdata == 32'h0; endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("stray data");
    property p_unmapped; s_setup ##0 paddr > 8'h0c |=> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped taken");
    property p_off_quiet;
        mode != 4'h7 && mode != 4'ha && stable > 4'h3
            |-> !monitor_bitstream_pin;
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("bitstream active while off");
    property p_recovery;
        stable > 4'h3 |-> recovery_active == (div > 8'h1);
    endproperty
    a_recovery: assert property (p_recovery)
        else $error("recovery state wrong for divider");
endmodule

bind demod_monitor_sigma_delta demod_monitor_sigma_delta_chk u_chk (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .linear_demod, .corr_demod, .monitor_bitstream_pin,
    .recovery_active
);

// file: tb_demod_monitor_sigma_delta.sv
// Self-checking testbench for the demodulator monitor converter
`timescale 1ns/1ps
module tb_demod_monitor_sigma_delta;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        bitstream, recovery_active, gate;
    logic [7:0]  paddr;
    logic [15:0] linear_demod, corr_demod, ones;
    logic [31:0] pwdata, prdata, rd;
    int          fails, samples_checked;

    demod_monitor_sigma_delta uut (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .linear_demod, .corr_demod,
        .monitor_bitstream_pin(bitstream), .recovery_active
    );
    bitstream_meter meter (.pclk, .presetn, .gate, .bitstream, .ones);

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic finish_test();
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; answer taken at the edge that sees pready high
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d, input logic e);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20) begin
            fails++;
        end
        rd = prdata;
        chk({31'h0, pslverr}, {31'h0, e});
        {psel, penable} <= 2'b00;
    endtask

    task automatic rdm(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] x, input logic e);
        apb(a, 1'b0, 32'h0, e);
        chk(rd & m, x);
    endtask

    task automatic dens(input int n, input logic [15:0] lo, hi);
        @(posedge pclk);
        gate <= 1'b1;
        repeat (n) @(posedge pclk);
        gate <= 1'b0;
        @(negedge pclk);
        samples_checked++;
        if ((ones >= lo && ones <= hi) !== 1'b1) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, ones, lo);
        end
    endtask

    initial begin
        repeat (50000) @(posedge pclk);
        fails++;
        finish_test();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, gate} = '0;
        {paddr, pwdata, linear_demod, corr_demod} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({30'h0, recovery_active, bitstream}, 32'h0);
        rdm(8'h08, 32'hffffffff, 32'h10, 1'b0);
        rdm(8'h00, 32'hffffffff, 32'h0, 1'b1);
        rdm(8'h20, 32'hffffffff, 32'h0, 1'b1);
        apb(8'h0c, 1'b1, 32'h0, 1'b1);
        apb(8'h04, 1'b1, 32'h0000000c, 1'b1);
        apb(8'h00, 1'b1, 32'h0000007d, 1'b1);
        {linear_demod, corr_demod} <= {16'h4000, 16'hc000};
        apb(8'h04, 1'b1, 32'h0000000d, 1'b0);
        apb(8'h00, 1'b1, 32'h0000007c, 1'b0);
        rdm(8'h0c, 32'hffff0003, 32'h40000001, 1'b0);
        dens(2000, 16'd1490, 16'd1510);
        apb(8'h08, 1'b1, 32'h00000011, 1'b0);
        rdm(8'h0c, 32'hffff0003, 32'hc0000001, 1'b0);
        dens(2000, 16'd490, 16'd510);
        apb(8'h08, 1'b1, 32'h00000010, 1'b0);
        apb(8'h04, 1'b1, 32'h1200000d, 1'b0);
        apb(8'h00, 1'b1, 32'h000000ac, 1'b0);
        rdm(8'h0c, 32'hffff0003, 32'h60000001, 1'b0);
        dens(2000, 16'd1740, 16'd1760);
        apb(8'h00, 1'b1, 32'h0000007c, 1'b0);
        rdm(8'h0c, 32'hffff0003, 32'h7fff0001, 1'b0);
        linear_demod <= 16'h0000;
        apb(8'h04, 1'b1, 32'h0fff000d, 1'b0);
        apb(8'h00, 1'b1, 32'h000000ac, 1'b0);
        rdm(8'h0c, 32'hffff0003, 32'h80080001, 1'b0);
        linear_demod <= 16'h4000;
        apb(8'h04, 1'b1, 32'h0000300d, 1'b0);
        apb(8'h08, 1'b1, 32'h00000040, 1'b0);
        apb(8'h00, 1'b1, 32'h0000007c, 1'b0);
        rdm(8'h0c, 32'hffff0003, 32'h40000003, 1'b0);
        dens(4000, 16'd2960, 16'd3040);
        apb(8'h00, 1'b1, 32'h0000000c, 1'b0);
        repeat (8) @(posedge pclk);
        rdm(8'h0c, 32'h00000007, 32'h00000002, 1'b0);
        finish_test();
    end
endmodule
